// ===== rtl/clkgen_pkg.sv
package clkgen_pkg;

    // ------------------------------------------------------------
    // I/O port addresses
    // ------------------------------------------------------------
    localparam int IO_AW = 10;
    localparam logic [IO_AW-1:0] SPEED_SEL_ADDR = 10'h063;
    localparam logic [IO_AW-1:0] TIMING_PTR_ADDR = 10'h072;
    localparam logic [IO_AW-1:0] TIMING_DATA_ADDR = 10'h073;

    // ------------------------------------------------------------
    // Speed-select register layout
    // ------------------------------------------------------------
    localparam logic [7:0] SPEED_RESET = 8'h00;
    localparam logic [7:0] SPEED_USED_MASK = 8'hcc;
    localparam int SS_FAST_SEL = 2;
    localparam int SS_XFER_HIGH = 3;
    localparam int SS_SLEEP = 6;
    localparam int SS_UNLOCK = 7;

    // ------------------------------------------------------------
    // Command-timing register file
    // ------------------------------------------------------------
    localparam int TIMING_AW = 4;
    localparam int TIMING_W = 4;
    localparam int TIMING_DEPTH = 16;
    localparam logic [TIMING_AW-1:0] TIMING_UNUSED_IDX = 4'h2;
    localparam logic [TIMING_AW-1:0] TIMING_LAST_IDX = 4'hc;
    localparam logic [63:0] TIMING_DEFAULTS = 64'h0001_0100_1014_1010;
    localparam logic [TIMING_W-1:0] TIMING_ZERO = 4'h0;

    // ------------------------------------------------------------
    // Divider half periods, counted in source rising edges
    // ------------------------------------------------------------
    localparam int DIV_CW = 3;
    localparam logic [DIV_CW-1:0] XFER_FAST_HI_HALF = 3'h2;  // fast / 4
    localparam logic [DIV_CW-1:0] XFER_FAST_LO_HALF = 3'h4;  // fast / 8
    localparam logic [DIV_CW-1:0] XFER_PRI_HI_HALF = 3'h1;   // pri / 2
    localparam logic [DIV_CW-1:0] XFER_PRI_LO_HALF = 3'h2;   // pri / 4
    localparam logic [DIV_CW-1:0] KBD_HALF = 3'h1;           // ref / 2
    localparam logic [DIV_CW-1:0] TMR_HALF = 3'h6;           // ref / 12

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 25;
    localparam int PRI_IDLE_NS = 1000;
    localparam int PRI_IDLE_CYC = PRI_IDLE_NS / CLK_PERIOD_NS;
    localparam int IDLE_CW = 6;

    // Gather bits 7, 6, 3, 2 of an I/O byte into a nibble, bit 2 as LSB
    function automatic logic [3:0] pack_nibble(input logic [7:0] b);
        return {b[7], b[6], b[3], b[2]};
    endfunction

endpackage

// ===== rtl/clk_divider.sv
`timescale 1ns/100ps
module clk_divider
    import clkgen_pkg::*;
#(
    parameter int CW = DIV_CW
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic tick,
    input wire logic run,
    input wire logic [CW-1:0] half_count,
    output logic clk_out
);

    logic [CW-1:0] cnt_q;
    logic [CW-1:0] half_q;
    logic wrap;

    assign wrap = tick && (cnt_q == CW'(half_q - 1'b1));

    // ------------------------------------------------------------
    // Divider
    // ------------------------------------------------------------
    // New divisor is taken only at the start of a low phase, so a
    // change never clips a pulse already under way
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            half_q <= CW'(1);
        end else if (!clk_out && cnt_q == '0) begin
            half_q <= half_count;
        end
    end

    // Count source edges; a stopped divider finishes its high phase
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            cnt_q <= '0;
            clk_out <= 1'b0;
        end else if (wrap) begin
            cnt_q <= '0;
            clk_out <= !clk_out && run;
        end else if (tick) begin
            cnt_q <= CW'(cnt_q + 1'b1);
        end
    end

endmodule // clk_divider

// ===== rtl/timing_reg_file.sv
`timescale 1ns/100ps
module timing_reg_file
    import clkgen_pkg::*;
#(
    parameter int AW = TIMING_AW,
    parameter int W = TIMING_W,
    parameter int DEPTH = TIMING_DEPTH
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic wr_en,
    input wire logic [AW-1:0] wr_idx,
    input wire logic [W-1:0] wr_data,
    input wire logic [AW-1:0] rd_idx,
    output logic [W-1:0] rd_data
);

    logic [W-1:0] mem_q [DEPTH];

    // ------------------------------------------------------------
    // Storage, loaded with the power-on timing values
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem_q[i] <= TIMING_DEFAULTS[i*W +: W];
            end
        end else if (wr_en) begin
            mem_q[wr_idx] <= wr_data;
        end
    end

    // Registered read for the command-timing logic elsewhere
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            rd_data <= TIMING_ZERO;
        end else begin
            rd_data <= mem_q[rd_idx];
        end
    end

endmodule // timing_reg_file

// ===== rtl/system_clock_generator.sv
`timescale 1ns/100ps
module system_clock_generator
    import clkgen_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [IO_AW-1:0] io_addr,
    input wire logic [7:0] io_wdata,
    input wire logic io_wr,
    input wire logic primary_osc_in,
    input wire logic fast_osc_in,
    input wire logic reference_osc_in,
    input wire logic addr_latch_en,
    input wire logic processor_reset_in,
    input wire logic [TIMING_AW-1:0] timing_rd_idx,
    output logic [TIMING_W-1:0] timing_rd_data,
    output logic processor_clk_out,
    output logic expansion_bus_clk,
    output logic transfer_ctrl_clk,
    output logic kbd_ctrl_clk,
    output logic kbd_ctrl_clk_inv,
    output logic interval_timer_clk,
    output logic numeric_coproc_clk,
    output logic sleep_active
);

    logic [7:0] speed_q;
    logic [TIMING_AW-1:0] ptr_q;
    logic sleep_q;
    logic cpu_fast_q;
    logic fast_prev_q;
    logic ref_prev_q;
    logic cpu_rst_prev_q;
    logic pri_prev_q;
    logic pri_tied_q;
    logic [IDLE_CW-1:0] idle_cnt_q;
    logic pri_lvl_q;
    logic pri_lvl_d;
    logic bus_phase_q;
    logic fast_rise, fast_fall, pri_rise, pri_fall, ref_rise;
    logic src_rise, src_fall, wake_pulse;
    logic wr_speed, wr_ptr, wr_data, timing_wr;
    logic [DIV_CW-1:0] xfer_half;
    logic [TIMING_W-1:0] data_nib;

    // ------------------------------------------------------------
    // I/O write decode
    // ------------------------------------------------------------
    assign wr_speed = io_wr && io_addr == SPEED_SEL_ADDR;
    assign wr_ptr = io_wr && io_addr == TIMING_PTR_ADDR && speed_q[SS_UNLOCK];
    assign wr_data = io_wr && io_addr == TIMING_DATA_ADDR
        && speed_q[SS_UNLOCK];
    assign data_nib = pack_nibble(io_wdata);
    // Unused and absent timing slots drop the write
    assign timing_wr = wr_data && ptr_q != TIMING_UNUSED_IDX
        && ptr_q <= TIMING_LAST_IDX;
    assign wake_pulse = processor_reset_in && !cpu_rst_prev_q;

    // Speed register; unused bits never stored, wake clears sleep bit
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            speed_q <= SPEED_RESET;
        end else if (wake_pulse) begin
            speed_q[SS_SLEEP] <= 1'b0;
        end else if (wr_speed) begin
            speed_q <= io_wdata & SPEED_USED_MASK;
        end
    end

    // Sleep is left only by reset or a processor-reset pulse, never by a write
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            sleep_q <= 1'b0;
        end else if (wake_pulse) begin
            sleep_q <= 1'b0;
        end else if (wr_speed && io_wdata[SS_SLEEP]) begin
            sleep_q <= 1'b1;
        end
    end
    assign sleep_active = sleep_q;

    // Pointer for the command-timing registers
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            ptr_q <= '0;
        end else if (wr_ptr) begin
            ptr_q <= pack_nibble(io_wdata);
        end
    end

    timing_reg_file u_timing (
        .clk_sys(clk_sys),
        .rst(rst),
        .wr_en(timing_wr),
        .wr_idx(ptr_q),
        .wr_data(data_nib),
        .rd_idx(timing_rd_idx),
        .rd_data(timing_rd_data)
    );

    // ------------------------------------------------------------
    // Input edge detection
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            fast_prev_q <= 1'b0;
            ref_prev_q <= 1'b0;
            pri_prev_q <= 1'b0;
            cpu_rst_prev_q <= 1'b0;
        end else begin
            fast_prev_q <= fast_osc_in;
            ref_prev_q <= reference_osc_in;
            pri_prev_q <= primary_osc_in;
            cpu_rst_prev_q <= processor_reset_in;
        end
    end
    assign fast_rise = fast_osc_in && !fast_prev_q;
    assign fast_fall = !fast_osc_in && fast_prev_q;
    assign ref_rise = reference_osc_in && !ref_prev_q;

    // A primary input that stays high with no edge counts as tied;
    // sampling beats cannot fake this since any edge restarts it
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            idle_cnt_q <= '0;
            pri_tied_q <= 1'b0;
        end else if (primary_osc_in != pri_prev_q || !primary_osc_in) begin
            idle_cnt_q <= '0;
            pri_tied_q <= 1'b0;
        end else if (idle_cnt_q == IDLE_CW'(PRI_IDLE_CYC)) begin
            pri_tied_q <= 1'b1;
        end else begin
            idle_cnt_q <= IDLE_CW'(idle_cnt_q + 1'b1);
        end
    end

    // Internal primary source: real input, or fast input halved
    always_comb begin
        if (pri_tied_q) begin
            pri_lvl_d = fast_rise ? !pri_lvl_q : pri_lvl_q;
        end else begin
            pri_lvl_d = primary_osc_in;
        end
    end
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            pri_lvl_q <= 1'b0;
        end else begin
            pri_lvl_q <= pri_lvl_d;
        end
    end
    assign pri_rise = pri_lvl_d && !pri_lvl_q;
    assign pri_fall = !pri_lvl_d && pri_lvl_q;

    // ------------------------------------------------------------
    // Processor clock
    // ------------------------------------------------------------
    assign src_rise = cpu_fast_q ? fast_rise : pri_rise;
    assign src_fall = cpu_fast_q ? fast_fall : pri_fall;

    // Source swaps as the current source falls or while the processor
    // clock is low, so the high phase in progress is never cut short
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            cpu_fast_q <= 1'b0;
        end else if (src_fall || !processor_clk_out) begin
            cpu_fast_q <= speed_q[SS_FAST_SEL];
        end
    end

    // Follows the selected source edge for edge; sleep blocks rises
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            processor_clk_out <= 1'b0;
        end else if (src_fall) begin
            processor_clk_out <= 1'b0;
        end else if (src_rise && !sleep_q) begin
            processor_clk_out <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Expansion-bus clock
    // ------------------------------------------------------------
    // Fast: toggle on every second rise; the strobe realigns phase
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            bus_phase_q <= 1'b0;
            expansion_bus_clk <= 1'b0;
        end else if (cpu_fast_q) begin
            if (addr_latch_en && fast_fall) begin
                bus_phase_q <= 1'b0;
                expansion_bus_clk <= 1'b0;
            end else if (fast_rise) begin
                bus_phase_q <= !bus_phase_q;
                if (bus_phase_q) begin
                    expansion_bus_clk <= !expansion_bus_clk && !sleep_q;
                end
            end
        end else if (pri_rise) begin
            bus_phase_q <= 1'b0;
            expansion_bus_clk <= !expansion_bus_clk && !sleep_q;
        end
    end

    // ------------------------------------------------------------
    // Transfer-controller, keyboard and timer clocks
    // ------------------------------------------------------------
    always_comb begin
        if (cpu_fast_q) begin
            xfer_half = speed_q[SS_XFER_HIGH] ? XFER_FAST_HI_HALF
                : XFER_FAST_LO_HALF;
        end else begin
            xfer_half = speed_q[SS_XFER_HIGH] ? XFER_PRI_HI_HALF
                : XFER_PRI_LO_HALF;
        end
    end

    clk_divider u_xfer_div (
        .clk_sys(clk_sys),
        .rst(rst),
        .tick(src_rise),
        .run(!sleep_q),
        .half_count(xfer_half),
        .clk_out(transfer_ctrl_clk)
    );

    // Reference dividers ignore both selection and sleep
    clk_divider u_kbd_div (
        .clk_sys(clk_sys),
        .rst(rst),
        .tick(ref_rise),
        .run(1'b1),
        .half_count(KBD_HALF),
        .clk_out(kbd_ctrl_clk)
    );
    assign kbd_ctrl_clk_inv = !kbd_ctrl_clk;

    clk_divider u_tmr_div (
        .clk_sys(clk_sys),
        .rst(rst),
        .tick(ref_rise),
        .run(1'b1),
        .half_count(TMR_HALF),
        .clk_out(interval_timer_clk)
    );

    // ------------------------------------------------------------
    // Coprocessor clock: internal primary, which is fast/2 when tied
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            numeric_coproc_clk <= 1'b0;
        end else if (pri_fall) begin
            numeric_coproc_clk <= 1'b0;
        end else if (pri_rise && !sleep_q) begin
            numeric_coproc_clk <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    cpu_fast_follow_a: assert property (
        @(posedge clk_sys) disable iff (rst)
        cpu_fast_q && fast_rise && !fast_fall && !sleep_q
        |=> processor_clk_out)
        else $error("processor clock missed a fast source rise");
    fast_select_bit_a: assert property (
        @(posedge clk_sys) disable iff (rst)
        wr_speed && !wake_pulse
        |=> speed_q[SS_FAST_SEL] == $past(io_wdata[SS_FAST_SEL]))
        else $error("source select bit not stored");
    unused_bits_zero_a: assert property (
        @(posedge clk_sys) disable iff (rst)
        (speed_q & ~SPEED_USED_MASK) == 8'h00)
        else $error("unused speed bits were stored");
    reset_clears_a: assert property (
        @(posedge clk_sys)
        rst |=> speed_q == SPEED_RESET && !sleep_q)
        else $error("speed register not cleared by reset");
    sleep_stops_a: assert property (
        @(posedge clk_sys) disable iff (rst)
        sleep_q && $past(sleep_q)
        |-> !$rose(processor_clk_out) && !$rose(expansion_bus_clk)
            && !$rose(numeric_coproc_clk))
        else $error("stopped clock rose during sleep");
    wake_ends_a: assert property (
        @(posedge clk_sys) disable iff (rst)
        wake_pulse |=> !sleep_q ##0 !speed_q[SS_SLEEP])
        else $error("reset pulse did not end sleep");
    bus_align_a: assert property (
        @(posedge clk_sys) disable iff (rst)
        cpu_fast_q && addr_latch_en && fast_fall |=> !expansion_bus_clk)
        else $error("bus clock not forced low on strobe");
    ptr_locked_a: assert property (
        @(posedge clk_sys) disable iff (rst)
        !speed_q[SS_UNLOCK] |=> $stable(ptr_q))
        else $error("pointer changed while locked");
    // Keyboard clock is reference/2, so every reference rise toggles it
    kbd_divide_a: assert property (
        @(posedge clk_sys) disable iff (rst)
        ref_rise |=> kbd_ctrl_clk != $past(kbd_ctrl_clk))
        else $error("keyboard clock missed a reference rise");
    tied_halving_a: assert property (
        @(posedge clk_sys) disable iff (rst)
        pri_tied_q && fast_rise |=> pri_lvl_q != $past(pri_lvl_q))
        else $error("tied primary not fed fast/2");

endmodule // system_clock_generator

// ===== verif/osc_board_model.sv
`timescale 1ns/100ps
// --------
// Board oscillators feeding the clock block
// --------
module osc_board_model #(
    parameter int FAST_HALF = 4,
    parameter int PRI_HALF = 8,
    parameter int REF_HALF = 4
) (
    input wire logic clk_sys,
    input wire logic primary_tied,
    output logic primary_osc_in,
    output logic fast_osc_in,
    output logic reference_osc_in
);
    int cnt;

    // Known levels before the first edge
    initial begin
        cnt = 0;
        primary_osc_in = 1'b0;
        fast_osc_in = 1'b0;
        reference_osc_in = 1'b0;
    end

    // Slow stand-ins: each level lasts several clk_sys cycles, so
    // no edge can slip between two samples of the block
    always @(posedge clk_sys) begin
        #1;
        cnt = cnt + 1;
        fast_osc_in = ((cnt / FAST_HALF) % 2) == 1;
        // Pull-up on the unused primary input holds it high
        primary_osc_in = primary_tied | (((cnt / PRI_HALF) % 2) == 1);
        reference_osc_in = (((cnt + 1) / REF_HALF) % 2) == 1;
    end
endmodule // osc_board_model

// ===== verif/system_clock_generator_tb_top.sv
`timescale 1ns/100ps
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin n_fail++; \
    $display("ERROR t=%0t got %0h exp %0h", $time, a, e); end end
module system_clock_generator_tb_top
    import clkgen_pkg::*;
();
    localparam int FAST_P = 8;
    localparam int PRI_P = 16;
    localparam int REF_P = 8;
    localparam int WIN = 384;
    logic clk_sys, rst, io_wr, addr_latch_en, processor_reset_in;
    logic [IO_AW-1:0] io_addr;
    logic [7:0] io_wdata;
    logic primary_osc_in, fast_osc_in, reference_osc_in, primary_tied;
    logic [TIMING_AW-1:0] timing_rd_idx;
    logic [TIMING_W-1:0] timing_rd_data;
    logic processor_clk_out, expansion_bus_clk, transfer_ctrl_clk;
    logic kbd_ctrl_clk, kbd_ctrl_clk_inv, interval_timer_clk;
    logic numeric_coproc_clk, sleep_active;
    logic [5:0] outs, prev_q;
    logic [3:0] tm [16];
    int rises [6];
    bit counting;
    int n_fail, num_checks, seed;

    system_clock_generator u_system_clock_generator (
        .clk_sys(clk_sys), .rst(rst), .io_addr(io_addr),
        .io_wdata(io_wdata), .io_wr(io_wr),
        .primary_osc_in(primary_osc_in), .fast_osc_in(fast_osc_in),
        .reference_osc_in(reference_osc_in),
        .addr_latch_en(addr_latch_en),
        .processor_reset_in(processor_reset_in),
        .timing_rd_idx(timing_rd_idx), .timing_rd_data(timing_rd_data),
        .processor_clk_out(processor_clk_out),
        .expansion_bus_clk(expansion_bus_clk),
        .transfer_ctrl_clk(transfer_ctrl_clk),
        .kbd_ctrl_clk(kbd_ctrl_clk), .kbd_ctrl_clk_inv(kbd_ctrl_clk_inv),
        .interval_timer_clk(interval_timer_clk),
        .numeric_coproc_clk(numeric_coproc_clk),
        .sleep_active(sleep_active)
    );

    osc_board_model #(
        .FAST_HALF(FAST_P / 2),
        .PRI_HALF(PRI_P / 2),
        .REF_HALF(REF_P / 2)
    ) u_osc_board_model (
        .clk_sys(clk_sys), .primary_tied(primary_tied),
        .primary_osc_in(primary_osc_in), .fast_osc_in(fast_osc_in),
        .reference_osc_in(reference_osc_in)
    );

    // 40 MHz system clock
    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end

    // --------
    // Edge counting on the generated clocks
    // --------
    assign outs = {numeric_coproc_clk, interval_timer_clk, kbd_ctrl_clk,
                   transfer_ctrl_clk, expansion_bus_clk, processor_clk_out};

    // Rising edges per output; the inverted keyboard clock is checked
    // every cycle of a window. Sampled on the falling edge, where no
    // output is being launched, to stay clear of the update race
    always @(negedge clk_sys) begin
        prev_q <= outs;
        if (counting) begin
            for (int i = 0; i < 6; i++)
                if (outs[i] === 1'b1 && prev_q[i] === 1'b0) rises[i]++;
            `CHK(kbd_ctrl_clk_inv, ~kbd_ctrl_clk)
        end
    end

    // Expected edges in one window for a source period and divisor
    function automatic int f(input int period, input int div);
        return WIN / (period * div);
    endfunction

    // Window phase may add or cost one edge; a stopped clock must show none
    function automatic bit near(input int got, input int e);
        return (e == 0) ? (got == 0) : (got >= e - 1 && got <= e + 1);
    endfunction

    function automatic logic [7:0] to_byte(input logic [3:0] n);
        return {n[3], n[2], 2'b00, n[1], n[0], 2'b00};
    endfunction

    // Random filler for the bits that carry nothing
    function automatic logic [7:0] junk();
        return 8'($random(seed)) & 8'h33;
    endfunction

    // --------
    // Bus and measurement tasks
    // --------
    task automatic wait_n(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask

    // One-cycle write strobe, then an idle cycle before the next
    task automatic wr(input logic [IO_AW-1:0] a, input logic [7:0] d);
        io_addr = a;
        io_wdata = d;
        io_wr = 1'b1;
        wait_n(1);
        io_wr = 1'b0;
        wait_n(1);
    endtask

    task automatic speed(input logic [7:0] v);
        wr(SPEED_SEL_ADDR, v | junk());
    endtask

    task automatic rd_chk(input logic [3:0] i);
        timing_rd_idx = i;
        wait_n(2);
        `CHK(timing_rd_data, tm[i])
    endtask

    task automatic set_t(input logic [3:0] i, input logic [3:0] v,
                         input bit open);
        wr(TIMING_PTR_ADDR, to_byte(i) | junk());
        wr(TIMING_DATA_ADDR, to_byte(v) | junk());
        if (open && i != 4'h2 && i <= 4'hc) tm[i] = v;
        rd_chk(i);
    endtask

    // Settle, then count edges; keyboard and timer never change
    task automatic measure(input int p, input int b, input int x,
                           input int c);
        int e [6];
        e = '{p, b, x, f(REF_P, 2), f(REF_P, 12), c};
        wait_n(64);
        for (int i = 0; i < 6; i++) rises[i] = 0;
        counting = 1'b1;
        wait_n(WIN);
        counting = 1'b0;
        for (int i = 0; i < 6; i++)
            `CHK(near(rises[i], e[i]), 1'b1)
    endtask

    task automatic close_out();
        if (n_fail == 0 && num_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // Hang guard, well above the expected run length
    initial begin
        repeat (20000) @(posedge clk_sys);
        n_fail++;
        close_out();
    end

    // --------
    // Main sequence
    // --------
    initial begin
        seed = 32'h4c6c;
        n_fail = 0;
        num_checks = 0;
        counting = 1'b0;
        rst = 1'b1;
        io_wr = 1'b0;
        io_addr = '0;
        io_wdata = 8'h00;
        addr_latch_en = 1'b0;
        processor_reset_in = 1'b0;
        timing_rd_idx = '0;
        primary_tied = 1'b0;
        tm = '{0, 1, 0, 1, 4, 1, 0, 1, 0, 0, 1, 0, 1, 0, 0, 0};
        wait_n(8);
        rst = 1'b0;
        `CHK(sleep_active, 1'b0)
        for (int i = 0; i < 16; i++) rd_chk(4'(i));
        measure(f(PRI_P, 1), f(PRI_P, 2), f(PRI_P, 4),
                f(PRI_P, 1));
        speed(8'h08);
        measure(f(PRI_P, 1), f(PRI_P, 2), f(PRI_P, 2),
                f(PRI_P, 1));
        speed(8'h04);
        measure(f(FAST_P, 1), f(FAST_P, 4), f(FAST_P, 8),
                f(PRI_P, 1));
        speed(8'h0c);
        measure(f(FAST_P, 1), f(FAST_P, 4), f(FAST_P, 4),
                f(PRI_P, 1));
        // Strobe held high in fast mode keeps restarting the bus phase
        speed(8'h04);
        addr_latch_en = 1'b1;
        measure(f(FAST_P, 1), 0, f(FAST_P, 8), f(PRI_P, 1));
        speed(8'h00);
        measure(f(PRI_P, 1), f(PRI_P, 2), f(PRI_P, 4),
                f(PRI_P, 1));
        addr_latch_en = 1'b0;
        // Timing registers: locked, then open with random traffic
        set_t(4'h0, 4'hf, 1'b0);
        speed(8'h80);
        for (int k = 0; k < 6; k++)
            set_t(4'($unsigned($random(seed)) % 13), 4'($random(seed)),
                  1'b1);
        set_t(4'h2, 4'h9, 1'b1);
        set_t(4'hd, 4'h7, 1'b1);
        // Pointer left on a live slot, so only the lock can refuse next
        set_t(4'hc, 4'h6, 1'b1);
        speed(8'h00);
        set_t(4'hc, 4'h3, 1'b0);
        // Other address must not reach the speed register
        wr(10'h064, 8'hc4);
        wait_n(2);
        `CHK(sleep_active, 1'b0)
        // Sleep, a clear of bit 6 that must not wake, then the wake pulse
        speed(8'h40);
        wait_n(2);
        `CHK(sleep_active, 1'b1)
        measure(0, 0, 0, 0);
        speed(8'h00);
        `CHK(sleep_active, 1'b1)
        processor_reset_in = 1'b1;
        wait_n(2);
        processor_reset_in = 1'b0;
        wait_n(2);
        `CHK(sleep_active, 1'b0)
        measure(f(PRI_P, 1), f(PRI_P, 2), f(PRI_P, 4),
                f(PRI_P, 1));
        // Single oscillator board: primary pulled high
        primary_tied = 1'b1;
        speed(8'h04);
        measure(f(FAST_P, 1), f(FAST_P, 4), f(FAST_P, 8),
                f(FAST_P, 2));
        speed(8'h00);
        measure(f(FAST_P, 2), f(FAST_P, 4), f(FAST_P, 8),
                f(FAST_P, 2));
        // Reset in mid-run returns every setting to its default
        primary_tied = 1'b0;
        speed(8'h8c);
        rst = 1'b1;
        wait_n(2);
        rst = 1'b0;
        `CHK(sleep_active, 1'b0)
        measure(f(PRI_P, 1), f(PRI_P, 2), f(PRI_P, 4),
                f(PRI_P, 1));
        // Defaults reloaded, and the timing registers locked again
        tm = '{0, 1, 0, 1, 4, 1, 0, 1, 0, 0, 1, 0, 1, 0, 0, 0};
        set_t(4'h0, 4'h9, 1'b0);
        rd_chk(4'h4);
        close_out();
    end
endmodule // system_clock_generator_tb_top
